// *** hdl/cmc_defs.vh ***
// Constants shared by the CAN mode control and status block
`ifndef CMC_DEFS_VH
`define CMC_DEFS_VH

// Register indices; byte address is four times the index
`define CMC_IDX_CTL        6'h00
`define CMC_IDX_STS        6'h01
`define CMC_IDX_TXS        6'h02
`define CMC_IDX_IRQ_EN     6'h04
`define CMC_IDX_ERR_EN     6'h05
`define CMC_IDX_MSB        7
`define CMC_IDX_LSB        2

// Control register fields
`define CMC_CTL_TIME_TRIG  7
`define CMC_CTL_AUTO_BOFF  6
`define CMC_CTL_AUTO_WAKE  5
`define CMC_CTL_NO_RETX    4
`define CMC_CTL_FIFO_LOCK  3
`define CMC_CTL_TX_ORDER   2
`define CMC_CTL_SLEEP      1
`define CMC_CTL_INIT       0
`define CMC_CTL_RESET      8'h02

// Status register fields
`define CMC_STS_RX         5
`define CMC_STS_TX         4
`define CMC_STS_WAKE       3
`define CMC_STS_ERR        2
`define CMC_STS_SLEEP_ACK  1
`define CMC_STS_INIT_ACK   0
`define CMC_STS_RESET      8'h02

// Transmit status fields: success bits start at 4, done bits at 0
`define CMC_TXS_OK_BASE    4
`define CMC_TXS_DONE_BASE  0
`define CMC_TXS_RESET      8'h00
`define CMC_MAILBOXES      3

// Interrupt enable register fields
`define CMC_IEN_WAKE       7
`define CMC_IEN_TX_EMPTY   0
`define CMC_IEN_RESET      8'h00

// Error enable register fields: bit 7 irq enable, bits 3:0 per source
`define CMC_EEN_IRQ        7
`define CMC_EEN_SRC_MSB    3
`define CMC_EEN_RESET      8'h00
`define CMC_ERR_SOURCES    4

// Bus timing counts: run length in bit times, bus-off length in runs
`define CMC_RUN_LEN        4'hB
`define CMC_BOFF_RUNS      8'h80

// AXI4-Lite responses
`define CMC_RESP_OKAY      2'h0
`define CMC_RESP_SLVERR    2'h2

`endif

// *** hdl/cmc_recessive_counter.v ***
// Counter that pulses after each run of consecutive recessive bits
`timescale 1ns/1ps
`include "cmc_defs.vh"

module cmc_recessive_counter (
	input  wire       clk,
	input  wire       srst,
	input  wire       clear,
	input  wire       bitTick,
	input  wire       rxLevel,
	output wire       runDone
);

	reg [3:0] runCnt_reg;
	reg       runDone_reg;

	assign runDone = runDone_reg;

	always @(posedge clk) begin
		if (srst) begin
			runCnt_reg  <= 4'h0;
			runDone_reg <= 1'b0;
		end else begin
			runDone_reg <= 1'b0;
			if (clear) begin
				runCnt_reg <= 4'h0;
			end else if (bitTick) begin
				// A dominant bit breaks the run
				if (!rxLevel) begin
					runCnt_reg <= 4'h0;
				end else if (runCnt_reg == `CMC_RUN_LEN - 4'h1) begin
					runCnt_reg  <= 4'h0;
					runDone_reg <= 1'b1;
				end else begin
					runCnt_reg <= runCnt_reg + 4'h1;
				end
			end
		end
	end

endmodule

// *** hdl/cmc_mode_control.v ***
// CAN mode control and status registers with an AXI4-Lite slave
//
// Operation
// - Time-trigger bit enables time-triggered mode
// - Bus-off exit automatic or by software
// - Auto wakeup on message clears sleep, sets flag
// - Without auto wakeup, software clears sleep
// - Sleep refused while bus active if auto wakeup is in the same write, flag set
// - No-retransmit bit selects single-shot sending
// - FIFO lock selects overwrite or discard
// - Order bit selects identifier or chronological
// - Sleep entered after current frame completes
// - Reset into sleep, control and status registers read 0x02
// - Init release waits eleven recessive bits
// - Init entered after current frame, ack set
// - Status shows receiver and transmitter activity
// - Start of frame in sleep sets wakeup flag
// - Enabled error source sets error flag
// - Sleep acknowledge follows sleep mode
// - Init acknowledge clears after bus synchronisation
// - Per-mailbox success bit set and cleared
// - Per-mailbox request-done flag, write one clears
// - Transmit interrupt on done flag when enabled
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cmc_defs.vh"

module cmc_mode_control (
	input  wire        clk,
	input  wire        srst,
	// AXI4-Lite slave
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// Bus side
	input  wire        canRx,
	input  wire        bitTick,
	input  wire        frameActive,
	input  wire        isReceiving,
	input  wire        isTransmitting,
	input  wire        busOffEnter,
	input  wire [3:0]  errSourceSet,
	input  wire [2:0]  txRequest,
	input  wire [2:0]  txComplete,
	input  wire [2:0]  txCompleteOk,
	// Configuration and mode towards the protocol engine; interrupt lines towards the system
	output wire        timeTriggerEnable,
	output wire        noRetransmit,
	output wire        rxFifoLock,
	output wire        txOrderSelect,
	output wire        sleepMode,
	output wire        initMode,
	output wire        normalMode,
	output wire        busOffActive,
	output wire        statusIrq,
	output wire        txIrq
);

	localparam [1:0] ST_SLEEP  = 2'h0;
	localparam [1:0] ST_INIT   = 2'h1;
	localparam [1:0] ST_SYNC   = 2'h2;
	localparam [1:0] ST_NORMAL = 2'h3;

	reg  [1:0]  state_reg;
	reg  [7:0]  ctl_reg;
	reg  [7:0]  irqEn_reg;
	reg  [7:0]  errEn_reg;
	reg         wakeFlag_reg;
	reg         errFlag_reg;
	reg         initAck_reg;
	reg         rxAct_reg;
	reg         txAct_reg;
	reg  [2:0]  txOk_reg;
	reg  [2:0]  reqDone_reg;
	reg         busOff_reg;
	reg         swRecovery_reg;
	reg  [7:0]  boffRuns_reg;
	reg         statusIrq_reg;
	reg         txIrq_reg;
	reg         rxS1_reg;
	reg         rxS2_reg;
	reg         rxS3_reg;
	reg         rxLevel_reg;

	reg  [7:0]  awAddr_reg;
	reg         awHeld_reg;
	reg  [7:0]  wData_reg;
	reg         wStrb_reg;
	reg         wHeld_reg;
	reg         bvalid_reg;
	reg  [1:0]  bresp_reg;
	reg         rvalid_reg;
	reg  [7:0]  rdata_reg;
	reg  [1:0]  rresp_reg;
	reg  [7:0]  rdata_next;
	reg         rdMapped;

	wire        runDone;
	wire [5:0]  wrIdx = awAddr_reg[`CMC_IDX_MSB:`CMC_IDX_LSB];
	wire [5:0]  rdIdx = s_axi_araddr[`CMC_IDX_MSB:`CMC_IDX_LSB];
	wire        wrFire = awHeld_reg && wHeld_reg && !bvalid_reg;
	wire        wrMapped = (wrIdx == `CMC_IDX_CTL) || (wrIdx == `CMC_IDX_STS) ||
	                       (wrIdx == `CMC_IDX_TXS) || (wrIdx == `CMC_IDX_IRQ_EN) ||
	                       (wrIdx == `CMC_IDX_ERR_EN);
	wire        wrEn = wrFire && wStrb_reg;
	wire        wrCtl = wrEn && (wrIdx == `CMC_IDX_CTL);
	wire        wrSts = wrEn && (wrIdx == `CMC_IDX_STS);
	wire        wrTxs = wrEn && (wrIdx == `CMC_IDX_TXS);
	wire        rdFire = s_axi_arvalid && !rvalid_reg;

	wire        autoWake = ctl_reg[`CMC_CTL_AUTO_WAKE];
	wire        sleepAck = (state_reg == ST_SLEEP);
	// Falling edge of the filtered receive level marks a start of frame
	wire        rxAgree = (rxS2_reg == rxS3_reg);
	wire        sofEdge = rxAgree && !rxS2_reg && rxLevel_reg;
	wire        wakeByBus = (state_reg == ST_SLEEP) && autoWake && sofEdge;
	wire        refuseSleep = wrCtl && wData_reg[`CMC_CTL_SLEEP] &&
	                          wData_reg[`CMC_CTL_AUTO_WAKE] && frameActive;
	wire        monitorBoff = busOff_reg && (state_reg == ST_NORMAL) &&
	                          (ctl_reg[`CMC_CTL_AUTO_BOFF] || swRecovery_reg);
	wire        errEvent = |(errSourceSet & errEn_reg[`CMC_EEN_SRC_MSB:0]);
	wire [7:0]  stsView = {2'h0, rxAct_reg, txAct_reg, wakeFlag_reg, errFlag_reg,
	                       sleepAck, initAck_reg};
	wire [7:0]  txsView = {1'b0, txOk_reg, 1'b0, reqDone_reg};

	assign s_axi_awready = !awHeld_reg;
	assign s_axi_wready  = !wHeld_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = {24'h00_0000, rdata_reg};

	assign timeTriggerEnable = ctl_reg[`CMC_CTL_TIME_TRIG];
	assign noRetransmit      = ctl_reg[`CMC_CTL_NO_RETX];
	assign rxFifoLock        = ctl_reg[`CMC_CTL_FIFO_LOCK];
	assign txOrderSelect     = ctl_reg[`CMC_CTL_TX_ORDER];
	assign sleepMode         = (state_reg == ST_SLEEP);
	assign initMode          = (state_reg == ST_INIT);
	assign normalMode        = (state_reg == ST_NORMAL);
	assign busOffActive      = busOff_reg;
	assign statusIrq         = statusIrq_reg;
	assign txIrq             = txIrq_reg;

	// Three-stage receive synchroniser; level changes once stages two and three agree
	always @(posedge clk) begin
		if (srst) begin
			rxS1_reg    <= 1'b1;
			rxS2_reg    <= 1'b1;
			rxS3_reg    <= 1'b1;
			rxLevel_reg <= 1'b1;
		end else begin
			rxS1_reg <= canRx;
			rxS2_reg <= rxS1_reg;
			rxS3_reg <= rxS2_reg;
			if (rxAgree) begin
				rxLevel_reg <= rxS2_reg;
			end
		end
	end

	// Counting only makes sense while the node listens to the bus
	// Bus-off entry restarts the run so idle bits from before it never count
	cmc_recessive_counter u_runs (
		.clk     (clk),
		.srst    (srst),
		.clear   ((state_reg == ST_SLEEP) || (state_reg == ST_INIT) || busOffEnter),
		.bitTick (bitTick),
		.rxLevel (rxLevel_reg),
		.runDone (runDone)
	);

	// Mode sequencing
	always @(posedge clk) begin
		if (srst) begin
			state_reg <= ST_SLEEP;
		end else begin
			case (state_reg)
				ST_SLEEP: begin
					if (wakeByBus || !ctl_reg[`CMC_CTL_SLEEP]) begin
						state_reg <= ctl_reg[`CMC_CTL_INIT] ? ST_INIT : ST_SYNC;
					end
				end
				ST_INIT: begin
					if (!ctl_reg[`CMC_CTL_INIT]) begin
						state_reg <= ctl_reg[`CMC_CTL_SLEEP] ? ST_SLEEP : ST_SYNC;
					end
				end
				ST_SYNC, ST_NORMAL: begin
					if (ctl_reg[`CMC_CTL_INIT] && !frameActive) begin
						state_reg <= ST_INIT;
					end else if (ctl_reg[`CMC_CTL_SLEEP] && !frameActive) begin
						state_reg <= ST_SLEEP;
					end else if (state_reg == ST_SYNC && runDone) begin
						state_reg <= ST_NORMAL;
					end
				end
				default: begin
					state_reg <= ST_SLEEP;
				end
			endcase
		end
	end

	// Init acknowledge spans init mode and the following resynchronisation
	always @(posedge clk) begin
		if (srst) begin
			initAck_reg <= 1'b0;
		end else if (state_reg == ST_INIT) begin
			initAck_reg <= 1'b1;
		end else if (state_reg == ST_SYNC && runDone) begin
			initAck_reg <= 1'b0;
		end else if (state_reg == ST_SLEEP) begin
			initAck_reg <= 1'b0;
		end
	end

	// Control register; hardware may only clear the sleep request
	always @(posedge clk) begin
		if (srst) begin
			ctl_reg   <= `CMC_CTL_RESET;
			irqEn_reg <= `CMC_IEN_RESET;
			errEn_reg <= `CMC_EEN_RESET;
		end else begin
			if (wakeByBus) begin
				ctl_reg[`CMC_CTL_SLEEP] <= 1'b0;
			end
			if (wrCtl) begin
				ctl_reg <= wData_reg;
				// Auto wakeup must arrive in the same write as the sleep request
				ctl_reg[`CMC_CTL_SLEEP] <= wData_reg[`CMC_CTL_SLEEP] && !refuseSleep;
			end
			if (wrEn && wrIdx == `CMC_IDX_IRQ_EN) begin
				irqEn_reg <= wData_reg;
			end
			if (wrEn && wrIdx == `CMC_IDX_ERR_EN) begin
				errEn_reg <= wData_reg;
			end
		end
	end

	// Status flags; a hardware set beats a same-cycle software clear
	always @(posedge clk) begin
		if (srst) begin
			wakeFlag_reg <= 1'b0;
			errFlag_reg  <= 1'b0;
			rxAct_reg    <= 1'b0;
			txAct_reg    <= 1'b0;
		end else begin
			rxAct_reg <= isReceiving;
			txAct_reg <= isTransmitting;
			if ((state_reg == ST_SLEEP && sofEdge) || refuseSleep) begin
				wakeFlag_reg <= 1'b1;
			end else if (wrSts && wData_reg[`CMC_STS_WAKE]) begin
				wakeFlag_reg <= 1'b0;
			end
			if (errEvent) begin
				errFlag_reg <= 1'b1;
			end else if (wrSts && wData_reg[`CMC_STS_ERR]) begin
				errFlag_reg <= 1'b0;
			end
		end
	end

	// Per-mailbox completion and success flags
	genvar mb;
	generate
		for (mb = 0; mb < `CMC_MAILBOXES; mb = mb + 1) begin : g_mailbox
			wire doneClr = wrTxs && wData_reg[`CMC_TXS_DONE_BASE + mb];
			always @(posedge clk) begin
				if (srst) begin
					reqDone_reg[mb] <= 1'b0;
					txOk_reg[mb]    <= 1'b0;
				end else begin
					if (txComplete[mb]) begin
						reqDone_reg[mb] <= 1'b1;
					end else if (doneClr) begin
						reqDone_reg[mb] <= 1'b0;
					end
					if (txComplete[mb] && txCompleteOk[mb]) begin
						txOk_reg[mb] <= 1'b1;
					end else if (txRequest[mb] || doneClr) begin
						txOk_reg[mb] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Bus-off: 128 runs of 11 recessive bits, counted only in normal mode
	always @(posedge clk) begin
		if (srst) begin
			busOff_reg     <= 1'b0;
			swRecovery_reg <= 1'b0;
			boffRuns_reg   <= 8'h00;
		end else if (busOffEnter) begin
			busOff_reg     <= 1'b1;
			swRecovery_reg <= 1'b0;
			boffRuns_reg   <= 8'h00;
		end else if (busOff_reg) begin
			if (state_reg == ST_INIT) begin
				swRecovery_reg <= 1'b1;
				boffRuns_reg   <= 8'h00;
			end else if (monitorBoff && runDone) begin
				if (boffRuns_reg == `CMC_BOFF_RUNS - 8'h01) begin
					busOff_reg     <= 1'b0;
					swRecovery_reg <= 1'b0;
					boffRuns_reg   <= 8'h00;
				end else begin
					boffRuns_reg <= boffRuns_reg + 8'h01;
				end
			end
		end
	end

	// Interrupt lines towards the system
	always @(posedge clk) begin
		if (srst) begin
			statusIrq_reg <= 1'b0;
			txIrq_reg     <= 1'b0;
		end else begin
			statusIrq_reg <= (wakeFlag_reg && irqEn_reg[`CMC_IEN_WAKE]) ||
			                 (errFlag_reg && errEn_reg[`CMC_EEN_IRQ]);
			txIrq_reg     <= (|reqDone_reg) && irqEn_reg[`CMC_IEN_TX_EMPTY];
		end
	end

	// AXI4-Lite write: address and data taken in either order
	always @(posedge clk) begin
		if (srst) begin
			awAddr_reg <= 8'h00;
			awHeld_reg <= 1'b0;
			wData_reg  <= 8'h00;
			wStrb_reg  <= 1'b0;
			wHeld_reg  <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg  <= `CMC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !awHeld_reg) begin
				awAddr_reg <= s_axi_awaddr;
				awHeld_reg <= 1'b1;
			end
			if (s_axi_wvalid && !wHeld_reg) begin
				wData_reg <= s_axi_wdata[7:0];
				wStrb_reg <= s_axi_wstrb[0];
				wHeld_reg <= 1'b1;
			end
			if (wrFire) begin
				awHeld_reg <= 1'b0;
				wHeld_reg  <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg  <= wrMapped ? `CMC_RESP_OKAY : `CMC_RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Read data mux; status and transmit flags read back as live state
	always @* begin
		rdata_next = 8'h00;
		rdMapped   = 1'b1;
		case (rdIdx)
			`CMC_IDX_CTL:    rdata_next = ctl_reg;
			`CMC_IDX_STS:    rdata_next = stsView;
			`CMC_IDX_TXS:    rdata_next = txsView;
			`CMC_IDX_IRQ_EN: rdata_next = irqEn_reg;
			`CMC_IDX_ERR_EN: rdata_next = errEn_reg;
			default:         rdMapped   = 1'b0;
		endcase
	end

	always @(posedge clk) begin
		if (srst) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 8'h00;
			rresp_reg  <= `CMC_RESP_OKAY;
		end else if (rdFire) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rdata_next;
			rresp_reg  <= rdMapped ? `CMC_RESP_OKAY : `CMC_RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

endmodule

// *** bench/cmc_mode_control_assertions.sv ***
// Port-level checks for the CAN mode control block
`timescale 1ns/1ps
module cmc_mode_control_assertions (
	input logic       clk,
	input logic       srst,
	input logic       s_axi_awvalid,
	input logic       s_axi_awready,
	input logic       s_axi_wvalid,
	input logic       s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic       s_axi_bvalid,
	input logic       s_axi_bready,
	input logic       s_axi_arvalid,
	input logic       s_axi_arready,
	input logic       s_axi_rvalid,
	input logic       frameActive,
	input logic       bitTick,
	input logic       busOffEnter,
	input logic       sleepMode,
	input logic       initMode,
	input logic       normalMode,
	input logic       busOffActive
);
	localparam int BoffTicks = 1408;
	logic [11:0] tickCnt_reg;
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	// Saturates so a long idle spell cannot wrap and fake an early exit
	always @(posedge clk) begin
		if (srst || busOffEnter)
			tickCnt_reg <= 12'h000;
		else if (bitTick && tickCnt_reg != 12'hFFF)
			tickCnt_reg <= tickCnt_reg + 12'h001;
	end
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wrAnswer;
		##[1:3] s_axi_bvalid;
	endsequence
	sequence boffStays;
		busOffActive [*8];
	endsequence
	chk_write_answer: assert property (wrTaken |-> wrAnswer)
		else $error("write response missing");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data missing");
	chk_reset_sleep: assert property ($fell(srst) |-> sleepMode && !normalMode)
		else $error("not asleep after reset");
	chk_sleep_idle: assert property ($rose(sleepMode) && !$past(initMode) && !$past(srst) |-> !$past(frameActive))
		else $error("sleep entered during a frame");
	chk_init_idle: assert property ($rose(initMode) && !$past(sleepMode) && !$past(srst) |-> !$past(frameActive))
		else $error("init entered during a frame");
	chk_boff_hold: assert property ($rose(busOffActive) |-> boffStays)
		else $error("bus-off left at once");
	chk_boff_count: assert property ($fell(busOffActive) |-> tickCnt_reg >= BoffTicks)
		else $error("bus-off left too soon");
endmodule

bind cmc_mode_control cmc_mode_control_assertions cmc_mode_control_assertions_i (.*);

// *** bench/cmc_bus_node.sv ***
// Other nodes on the bus: bit clock, receive line and frame activity
`timescale 1ns/1ps
module cmc_bus_node (
	input  logic clk,
	input  logic srst,
	input  logic busy,
	output logic canRx,
	output logic bitTick,
	output logic frameActive
);
	logic [3:0] bitNum_reg;
	logic [1:0] tail_reg;
	initial begin
		canRx = 1'h1;
		bitTick = 1'h0;
		frameActive = 1'h0;
		bitNum_reg = 4'h0;
		tail_reg = 2'h0;
	end
	// Frame opens dominant; recessive end bits keep the bus busy a little longer
	always @(posedge clk) begin
		bitTick <= !bitTick && !srst;
		if (bitTick) begin
			canRx <= busy ? bitNum_reg[0] : 1'h1;
			bitNum_reg <= busy ? bitNum_reg + 4'h1 : 4'h0;
			tail_reg <= busy ? 2'h3 : tail_reg - (tail_reg != 2'h0);
			frameActive <= busy || tail_reg != 2'h0;
		end
	end
endmodule

// *** bench/cmc_mode_control_tb_top.sv ***
// Self-checking bench for the CAN mode control block
`timescale 1ns/1ps
module cmc_mode_control_tb_top;
	logic clk = 1'h0, srst = 1'h1, busy = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, seed = 32'h0000_0b5e;
	logic [3:0] s_axi_wstrb = 4'h0, errSourceSet = 4'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic isReceiving = 1'h0, isTransmitting = 1'h0, busOffEnter = 1'h0;
	logic [2:0] txRequest = 3'h0, txComplete = 3'h0, txCompleteOk = 3'h0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire canRx, bitTick, frameActive, timeTriggerEnable, noRetransmit, rxFifoLock;
	wire txOrderSelect, sleepMode, initMode, normalMode, busOffActive, statusIrq, txIrq;
	wire [3:0] modeVec = {busOffActive, sleepMode, initMode, normalMode};
	int badCount = 0, testsRun = 0;
	// Reference image of the mailbox flags, kept from the rules
	logic [2:0] doneModel = 3'h0, okModel = 3'h0;
	always #12.5 clk = !clk;
	cmc_mode_control cmc_mode_control_i (.*);
	cmc_bus_node cmc_bus_node_i (.clk(clk), .srst(srst), .busy(busy), .canRx(canRx),
		.bitTick(bitTick), .frameActive(frameActive));
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			badCount++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic reportAndStop;
		$display("Comparisons %0d, mismatches %0d", testsRun, badCount);
		if (badCount == 0 && testsRun > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] val, input logic [1:0] er);
		int n;
		@(posedge clk);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h0, val};
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1 && n < 50);
		s_axi_bready <= 1'h0;
		check("bresp", s_axi_bresp, er);
		check("bvalid", s_axi_bvalid, 1'h1);
		if (idx == 6'h02 && er == 2'h0) begin
			doneModel = doneModel & ~val[2:0];
			okModel = okModel & ~val[2:0];
		end
	endtask
	task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input logic [1:0] er);
		int n;
		@(posedge clk);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1 && n < 50);
		s_axi_rready <= 1'h0;
		check("rdata", s_axi_rdata, {24'h0, exp});
		check("rresp", s_axi_rresp, er);
		check("rvalid", s_axi_rvalid, 1'h1);
	endtask
	// Bounded wait on one mode bit: 0 normal, 1 init, 2 sleep, 3 bus-off
	task automatic waitUntil(input int sel, input logic val, output int cyc);
		cyc = 0;
		while (modeVec[sel] !== val && cyc < 4000) begin
			@(posedge clk);
			cyc++;
		end
		check("modeWait", modeVec[sel], val);
	endtask
	task automatic pulseBus(input logic [2:0] req, input logic [2:0] done, input logic [3:0] err);
		txRequest <= req;
		txComplete <= done;
		txCompleteOk <= done & 3'h5;
		errSourceSet <= err;
		@(posedge clk);
		okModel = (okModel & ~req) | (done & 3'h5);
		doneModel = doneModel | done;
		txRequest <= 3'h0;
		txComplete <= 3'h0;
		txCompleteOk <= 3'h0;
		errSourceSet <= 4'h0;
		@(posedge clk);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		badCount++;
		reportAndStop;
	end
	initial begin
		int cyc;
		logic [7:0] v;
		repeat (6) @(posedge clk);
		srst <= 1'h0;
		@(posedge clk);
		check("sleepMode", sleepMode, 1);
		rd(6'h00, 8'h02, 2'h0);
		rd(6'h01, 8'h02, 2'h0);
		rd(6'h02, 8'h00, 2'h0);
		rd(6'h03, 8'h00, 2'h2);
		wr(6'h07, 8'hFF, 2'h2);
		for (int k = 0; k < 4; k++) begin
			seed = xorshift(seed);
			v = seed[7:0] & 8'h9C | 8'h02;
			wr(6'h00, v, 2'h0);
			check("cfg", {timeTriggerEnable, noRetransmit, rxFifoLock, txOrderSelect}, {v[7], v[4:2]});
			rd(6'h00, v, 2'h0);
		end
		wr(6'h00, 8'h00, 2'h0);
		waitUntil(0, 1'h1, cyc);
		check("syncLen", cyc >= 20, 1);
		rd(6'h01, 8'h00, 2'h0);
		isReceiving <= 1'h1;
		rd(6'h01, 8'h20, 2'h0);
		isReceiving <= 1'h0;
		isTransmitting <= 1'h1;
		rd(6'h01, 8'h10, 2'h0);
		isTransmitting <= 1'h0;
		busy <= 1'h1;
		repeat (4) @(posedge clk);
		wr(6'h00, 8'h01, 2'h0);
		repeat (10) @(posedge clk);
		check("initEarly", initMode, 0);
		busy <= 1'h0;
		waitUntil(1, 1'h1, cyc);
		rd(6'h01, 8'h01, 2'h0);
		wr(6'h00, 8'h40, 2'h0);
		waitUntil(0, 1'h1, cyc);
		rd(6'h01, 8'h00, 2'h0);
		busOffEnter <= 1'h1;
		@(posedge clk);
		busOffEnter <= 1'h0;
		@(posedge clk);
		check("boffOn", busOffActive, 1);
		waitUntil(3, 1'h0, cyc);
		check("boffLen", cyc >= 2800 && cyc < 3000, 1);
		busy <= 1'h1;
		repeat (4) @(posedge clk);
		wr(6'h00, 8'h22, 2'h0);
		rd(6'h00, 8'h20, 2'h0);
		rd(6'h01, 8'h08, 2'h0);
		wr(6'h01, 8'h00, 2'h0);
		rd(6'h01, 8'h08, 2'h0);
		wr(6'h01, 8'h08, 2'h0);
		rd(6'h01, 8'h00, 2'h0);
		wr(6'h00, 8'h02, 2'h0);
		repeat (10) @(posedge clk);
		check("sleepEarly", sleepMode, 0);
		busy <= 1'h0;
		waitUntil(2, 1'h1, cyc);
		rd(6'h01, 8'h02, 2'h0);
		wr(6'h04, 8'h81, 2'h0);
		wr(6'h00, 8'h22, 2'h0);
		busy <= 1'h1;
		waitUntil(2, 1'h0, cyc);
		busy <= 1'h0;
		rd(6'h00, 8'h20, 2'h0);
		rd(6'h01, 8'h08, 2'h0);
		check("statusIrq", statusIrq, 1);
		wr(6'h01, 8'h08, 2'h0);
		@(posedge clk);
		check("statusIrq", statusIrq, 0);
		for (int m = 0; m < 3; m++) begin
			pulseBus(3'h1 << m, 3'h0, 4'h0);
			pulseBus(3'h0, 3'h1 << m, 4'h0);
		end
		rd(6'h02, {1'b0, okModel, 1'b0, doneModel}, 2'h0);
		check("txIrq", txIrq, 1);
		wr(6'h02, 8'h70, 2'h0);
		rd(6'h02, {1'b0, okModel, 1'b0, doneModel}, 2'h0);
		wr(6'h02, 8'h01, 2'h0);
		rd(6'h02, {1'b0, okModel, 1'b0, doneModel}, 2'h0);
		pulseBus(3'h4, 3'h0, 4'h0);
		rd(6'h02, {1'b0, okModel, 1'b0, doneModel}, 2'h0);
		wr(6'h02, 8'h06, 2'h0);
		@(posedge clk);
		check("txIrq", txIrq, 0);
		wr(6'h05, 8'h82, 2'h0);
		pulseBus(3'h0, 3'h0, 4'h1);
		rd(6'h01, 8'h00, 2'h0);
		pulseBus(3'h0, 3'h0, 4'h2);
		rd(6'h01, 8'h04, 2'h0);
		check("statusIrq", statusIrq, 1);
		busOffEnter <= 1'h1;
		@(posedge clk);
		busOffEnter <= 1'h0;
		repeat (3000) @(posedge clk);
		check("boffManual", busOffActive, 1);
		wr(6'h00, 8'h01, 2'h0);
		waitUntil(1, 1'h1, cyc);
		wr(6'h00, 8'h00, 2'h0);
		waitUntil(3, 1'h0, cyc);
		check("boffSw", cyc >= 2800 && cyc < 3100, 1);
		wr(6'h00, 8'h03, 2'h0);
		waitUntil(1, 1'h1, cyc);
		wr(6'h00, 8'h02, 2'h0);
		waitUntil(2, 1'h1, cyc);
		rd(6'h01, 8'h06, 2'h0);
		wr(6'h00, 8'h01, 2'h0);
		waitUntil(1, 1'h1, cyc);
		rd(6'h01, 8'h05, 2'h0);
		reportAndStop;
	end
endmodule
